// File: dv/clock_source_startup_control_chk.sv
`timescale 1ns/1ps
`include "clock_startup_regs.vh"
module clock_source_startup_control_chk (
  // Inputs
  input wire sys_clk,
  input wire rst,
  input wire otherResetActive,
  input wire converterQuiet,
  input wire wakeLevelIrq,
  // Outputs
  input wire internalReset,
  input wire [2:0] sourceKind,
  input wire [2:0] lowPowerRange,
  input wire coreClockEn,
  input wire programMemoryClockEn,
  input wire converterClockEn,
  input wire systemClockTick,
  input wire wakeIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rel; $fell(otherResetActive); endsequence
  sequence s_quiet; converterQuiet[*2]; endsequence
  property p_hold; otherResetActive[*5] |-> internalReset; endproperty
  property p_rel; s_rel |-> internalReset[*8]; endproperty
  property p_run; internalReset |-> !coreClockEn; endproperty
  property p_quiet; s_quiet |-> !coreClockEn; endproperty
  property p_conv; coreClockEn |-> converterClockEn; endproperty
  property p_flash; programMemoryClockEn == coreClockEn; endproperty
  property p_irq; wakeIrq |-> !$past(wakeIrq) && $past(wakeLevelIrq, 3); endproperty
  property p_div; systemClockTick |=> !systemClockTick; endproperty
  property p_lpr; sourceKind != `SRC_LOWPOWER |-> lowPowerRange == 3'h0; endproperty
  a_hold: assert property (p_hold) else $error("reset not held");
  a_rel: assert property (p_rel) else $error("early release");
  a_run: assert property (p_run) else $error("core runs in reset");
  a_quiet: assert property (p_quiet) else $error("core not halted");
  a_conv: assert property (p_conv) else $error("converter stopped");
  a_flash: assert property (p_flash) else $error("flash not with core");
  a_irq: assert property (p_irq) else $error("bad wake irq");
  a_div: assert property (p_div) else $error("tick too long");
  a_lpr: assert property (p_lpr) else $error("range outside low power");
endmodule // clock_source_startup_control_chk
bind clock_source_startup_control clock_source_startup_control_chk chk (.sys_clk, .rst,
  .otherResetActive, .converterQuiet, .wakeLevelIrq, .internalReset, .sourceKind,
  .lowPowerRange, .coreClockEn, .programMemoryClockEn, .converterClockEn,
  .systemClockTick, .wakeIrq);

// File: dv/clock_source_startup_control_tb.sv
`timescale 1ns/1ps
module clock_source_startup_control_tb;
  reg sys_clk = 0, rst = 1, fusesValid = 1, otherResetActive = 1, divideByEightFuse = 0;
  reg [3:0] clockSelectFuses = 4'h2;
  reg [1:0] startupTimeFuses = 2'h2;
  reg wakeRequest = 0, wakeLevelIrq = 0, sleepActive = 0, converterQuiet = 0;
  wire watchdogOscTick, oscTick, asyncTimerTick, internalReset, coreClockEn, wakeIrq;
  wire peripheralClockEn, programMemoryClockEn, asyncTimerClockEn, converterClockEn;
  wire systemClockTick;
  wire [2:0] sourceKind, lowPowerRange;
  int err_total = 0, checked = 0, irqN = 0, tickN = 0, asyN = 0, t;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
  osc_partner #(.HALF(2)) wdog (.sys_clk, .tick(watchdogOscTick));
  osc_partner #(.HALF(2)) osc (.sys_clk, .tick(oscTick));
  osc_partner #(.HALF(5)) asy (.sys_clk, .tick(asyncTimerTick));
  clock_source_startup_control uut (.sys_clk, .rst, .clockSelectFuses, .startupTimeFuses,
    .divideByEightFuse, .fusesValid, .otherResetActive, .watchdogOscTick, .oscTick,
    .asyncTimerTick, .wakeRequest, .wakeLevelIrq, .sleepActive, .converterQuiet,
    .internalReset, .sourceKind, .lowPowerRange, .coreClockEn, .peripheralClockEn,
    .programMemoryClockEn, .asyncTimerClockEn, .converterClockEn, .systemClockTick,
    .wakeIrq);
  initial forever #25 sys_clk = !sys_clk;
  always @(posedge sys_clk) begin
    irqN <= irqN + wakeIrq;
    tickN <= tickN + systemClockTick;
    asyN <= asyN + asyncTimerClockEn;
  end
  // ----
  // Tasks
  // ----
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task await_run;
    t = 0;
    while (coreClockEn !== 1'h1) begin
      step(1);
      t++;
      if (t > 40000) begin err_total++; tally_and_finish; end
    end
  endtask
  task boot(input logic [3:0] c, input logic [1:0] s, input int tout);
    otherResetActive = 1;
    clockSelectFuses = c;
    startupTimeFuses = s;
    step(6);
    otherResetActive = 0;
    await_run;
    `CHK("boot", 1'h1, t >= tout * 4 + 52 && t <= tout * 4 + 72)
  endtask
  task decode;
    for (int i = 0; i < 16; i++) begin
      clockSelectFuses = i[3:0];
      step(3);
      `CHK("kind", i > 7 ? 3'h6 : i > 5 ? 3'h5 : i > 3 ? 3'h4 : 3'(i), sourceKind)
      `CHK("range", i > 7 ? 3'(i >> 1) : 3'h0, lowPowerRange)
    end
  endtask
  task timeouts;
    // Low-power 101x only; zero time-out codes assume a brown-out detector
    for (int k = 0; k < 8; k++) begin
      if (k == 4 || k == 7) continue;
      boot({3'h5, k[2]}, k[1:0], k == 1 ? 8192 : (k == 2 || k == 5) ? 0 : 512);
    end
  endtask
  task divide(input int e);
    int a;
    a = tickN;
    step(256);
    `CHK("ticks", 1'h1, tickN - a >= e - 2 && tickN - a <= e + 2)
  endtask
  task quiet;
    converterQuiet = 1;
    step(3);
    `CHK("core", 1'h0, peripheralClockEn)
    `CHK("converter", 1'h1, converterClockEn)
    converterQuiet = 0;
    step(3);
  endtask
  task wake(input logic hold);
    int a;
    int b;
    a = irqN;
    sleepActive = 1;
    step(8);
    b = asyN;
    `CHK("asleep", 1'h0, programMemoryClockEn)
    sleepActive = 0;
    wakeLevelIrq = 1;
    wakeRequest = 1;
    step(20);
    wakeRequest = 0;
    wakeLevelIrq = hold;
    await_run;
    `CHK("wake", 1'h1, t >= 4040 && t <= 4100)
    `CHK("irq", hold, irqN > a)
    `CHK("async", 1'h1, asyN > b)
    wakeLevelIrq = 0;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    step(16);
    `CHK("reset kind", 3'h2, sourceKind)
    `CHK("reset hold", 1'h1, internalReset)
    rst = 0;
    step(2);
    decode;
    boot(4'h2, 2'h2, 0);
    divide(8);
    quiet;
    wake(1);
    wake(0);
    divideByEightFuse = 1;
    timeouts;
    divide(64);
    tally_and_finish;
  end
endmodule // clock_source_startup_control_tb

// File: dv/osc_partner.sv
`timescale 1ns/1ps
module osc_partner #(parameter int HALF = 2) (
  // Clock
  input wire logic sys_clk,
  // Oscillator output
  output logic tick
);
  int n = 0;
  initial tick = 1'h0;
  // Free-running square wave
  always @(posedge sys_clk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) tick <= !tick;
  end
endmodule // osc_partner

// File: hdl/clock_source_startup_control.v
`timescale 1ns/1ps
`include "clock_startup_regs.vh"
module clock_source_startup_control (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Fuses, active low when programmed
  input wire [3:0] clockSelectFuses,
  input wire [1:0] startupTimeFuses,
  input wire divideByEightFuse,
  input wire fusesValid,
  // Pins and events
  input wire otherResetActive,
  input wire watchdogOscTick,
  input wire oscTick,
  input wire asyncTimerTick,
  input wire wakeRequest,
  input wire wakeLevelIrq,
  // Sleep control
  input wire sleepActive,
  input wire converterQuiet,
  // Outputs
  output reg internalReset,
  output reg [2:0] sourceKind,
  output reg [2:0] lowPowerRange,
  output reg coreClockEn,
  output reg peripheralClockEn,
  output reg programMemoryClockEn,
  output reg asyncTimerClockEn,
  output reg converterClockEn,
  output reg systemClockTick,
  output reg wakeIrq
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_HOLD = 3'h0;
localparam ST_TIMEOUT = 3'h1;
localparam ST_OSC = 3'h2;
localparam ST_RUN = 3'h3;
localparam ST_SLEEP = 3'h4;

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [5:0] sync1_q;
reg [5:0] sync2_q;
wire [5:0] rawIn = {wakeLevelIrq, wakeRequest, asyncTimerTick, oscTick, watchdogOscTick,
  otherResetActive};
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    sync1_q <= 6'h00;
    sync2_q <= 6'h00;
  end else begin
    sync1_q <= rawIn;
    sync2_q <= sync1_q;
  end
end
wire otherRst = sync2_q[0];
wire asyncLvl = sync2_q[3];
wire wakeReq = sync2_q[4];
wire wakeLvl = sync2_q[5];

// ----------------------------------------
// Tick edge detect
// ----------------------------------------
reg wdPrev_q;
reg oscPrev_q;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    wdPrev_q <= 1'h0;
    oscPrev_q <= 1'h0;
  end else begin
    wdPrev_q <= sync2_q[1];
    oscPrev_q <= sync2_q[2];
  end
end
wire wdEdge = sync2_q[1] & ~wdPrev_q;
wire oscEdge = sync2_q[2] & ~oscPrev_q;

// ----------------------------------------
// Fuse capture
// ----------------------------------------
reg [3:0] cks_q;
reg [1:0] sut_q;
reg div8_q;
wire fuseLoad = fusesValid && otherRst;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    cks_q <= `DEFAULT_CLOCK_SELECT;
    sut_q <= `DEFAULT_STARTUP;
    div8_q <= `DEFAULT_DIV8;
  end else if (fuseLoad) begin
    cks_q <= clockSelectFuses;
    sut_q <= startupTimeFuses;
    div8_q <= divideByEightFuse;
  end
end

// ----------------------------------------
// Source decode
// ----------------------------------------
reg [2:0] kind;
always @* begin
  case (cks_q)
    `CKS_EXT_CLOCK: kind = `SRC_EXT;
    `CKS_RESERVED: kind = `SRC_RESERVED;
    `CKS_CAL_RC: kind = `SRC_CAL_RC;
    `CKS_RC_128K: kind = `SRC_RC_128K;
    `CKS_LOWFREQ_LO, `CKS_LOWFREQ_HI: kind = `SRC_LOWFREQ;
    `CKS_FULLSWING_LO, `CKS_FULLSWING_HI: kind = `SRC_FULLSWING;
    default: kind = `SRC_LOWPOWER;
  endcase
end

// ----------------------------------------
// Start-up delays
// ----------------------------------------
reg [13:0] toutCycles;
reg [14:0] wakeCycles;
reg lowBit;
always @* begin
  lowBit = cks_q[0];
  toutCycles = `TOUT_NONE;
  wakeCycles = `CK_1K;
  case ({lowBit, sut_q})
    3'h0: begin
      wakeCycles = `CK_258;
      toutCycles = `TOUT_SHORT;
    end
    3'h1: begin
      wakeCycles = `CK_258;
      toutCycles = `TOUT_LONG;
    end
    3'h2: begin
      wakeCycles = `CK_1K;
      toutCycles = `TOUT_NONE;
    end
    3'h3: begin
      wakeCycles = `CK_1K;
      toutCycles = `TOUT_SHORT;
    end
    3'h4: begin
      wakeCycles = `CK_1K;
      toutCycles = `TOUT_LONG;
    end
    3'h5: begin
      wakeCycles = `CK_16K;
      toutCycles = `TOUT_NONE;
    end
    3'h6: begin
      wakeCycles = `CK_16K;
      toutCycles = `TOUT_SHORT;
    end
    default: begin
      wakeCycles = `CK_16K;
      toutCycles = `TOUT_LONG;
    end
  endcase
end

// ----------------------------------------
// Start-up sequencer
// ----------------------------------------
reg [2:0] state_q;
reg [13:0] toutCnt_q;
reg [14:0] oscCnt_q;
reg fromReset_q;
reg levelLost_q;
wire [14:0] oscTarget = fromReset_q ? `CK_14 : wakeCycles;
wire toutDone = toutCnt_q >= toutCycles;
wire oscDone = oscCnt_q >= oscTarget;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    state_q <= ST_HOLD;
    toutCnt_q <= 14'h0000;
    oscCnt_q <= 15'h0000;
    fromReset_q <= 1'h1;
    levelLost_q <= 1'h0;
    wakeIrq <= 1'h0;
  end else begin
    wakeIrq <= 1'h0;
    if (otherRst) begin
      state_q <= ST_HOLD;
      fromReset_q <= 1'h1;
    end else begin
      case (state_q)
        ST_HOLD: begin
          toutCnt_q <= 14'h0000;
          oscCnt_q <= 15'h0000;
          levelLost_q <= 1'h0;
          state_q <= ST_TIMEOUT;
        end
        ST_TIMEOUT: begin
          if (!fromReset_q || toutDone) begin
            state_q <= ST_OSC;
          end else if (wdEdge) begin
            toutCnt_q <= toutCnt_q + 14'h0001;
          end
        end
        ST_OSC: begin
          if (!wakeLvl) levelLost_q <= 1'h1;
          if (oscDone) begin
            state_q <= ST_RUN;
            wakeIrq <= !fromReset_q && wakeLvl && !levelLost_q;
          end else if (oscEdge) begin
            oscCnt_q <= oscCnt_q + 15'h0001;
          end
        end
        ST_RUN: begin
          if (sleepActive) state_q <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (wakeReq) begin
            fromReset_q <= 1'h0;
            toutCnt_q <= 14'h0000;
            oscCnt_q <= 15'h0000;
            levelLost_q <= 1'h0;
            state_q <= ST_OSC;
          end
        end
        default: state_q <= ST_HOLD;
      endcase
    end
  end
end

// ----------------------------------------
// Clock domain gating terms
// ----------------------------------------
wire inRun = (state_q == ST_RUN);
wire inSleep = (state_q == ST_SLEEP);
wire coreGate = inRun && !converterQuiet;
wire converterGate = inRun || (inSleep && converterQuiet);
wire asyncGate = asyncLvl && !otherRst;

// ----------------------------------------
// System clock divider
// ----------------------------------------
reg [2:0] divCnt_q;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    divCnt_q <= 3'h0;
    systemClockTick <= 1'h0;
  end else if (!inRun) begin
    divCnt_q <= 3'h0;
    systemClockTick <= 1'h0;
  end else if (!div8_q) begin
    if (oscEdge) begin
      divCnt_q <= divCnt_q + 3'h1;
    end
    systemClockTick <= oscEdge && (divCnt_q == `DIV8_LAST);
  end else begin
    systemClockTick <= oscEdge;
  end
end

// ----------------------------------------
// Clock domain enables
// ----------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    internalReset <= 1'h1;
    sourceKind <= `SRC_CAL_RC;
    lowPowerRange <= 3'h0;
    coreClockEn <= 1'h0;
    peripheralClockEn <= 1'h0;
    programMemoryClockEn <= 1'h0;
    asyncTimerClockEn <= 1'h0;
    converterClockEn <= 1'h0;
  end else begin
    internalReset <= !inRun && !inSleep;
    sourceKind <= kind;
    lowPowerRange <= (kind == `SRC_LOWPOWER) ? cks_q[3:1] : 3'h0;
    coreClockEn <= coreGate;
    peripheralClockEn <= coreGate;
    programMemoryClockEn <= coreGate;
    asyncTimerClockEn <= asyncGate;
    converterClockEn <= converterGate;
  end
end

endmodule // clock_source_startup_control

// File: hdl/clock_startup_regs.vh
`ifndef CLOCK_STARTUP_REGS_VH
`define CLOCK_STARTUP_REGS_VH
// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define CKS_EXT_CLOCK 4'h0
`define CKS_RESERVED 4'h1
`define CKS_CAL_RC 4'h2
`define CKS_RC_128K 4'h3
`define CKS_LOWFREQ_LO 4'h4
`define CKS_LOWFREQ_HI 4'h5
`define CKS_FULLSWING_LO 4'h6
`define CKS_FULLSWING_HI 4'h7
`define CKS_LOWPOWER_LO 4'h8
// ----------------------------------------
// Source kinds
// ----------------------------------------
`define SRC_EXT 3'h0
`define SRC_RESERVED 3'h1
`define SRC_CAL_RC 3'h2
`define SRC_RC_128K 3'h3
`define SRC_LOWFREQ 3'h4
`define SRC_FULLSWING 3'h5
`define SRC_LOWPOWER 3'h6
// ----------------------------------------
// Factory defaults
// ----------------------------------------
`define DEFAULT_CLOCK_SELECT 4'h2
`define DEFAULT_STARTUP 2'h2
`define DEFAULT_DIV8 1'h0
// ----------------------------------------
// Counts
// ----------------------------------------
`define TOUT_NONE 14'h0000
`define TOUT_SHORT 14'h0200
`define TOUT_LONG 14'h2000
`define CK_258 15'h0102
`define CK_1K 15'h0400
`define CK_16K 15'h4000
`define CK_14 15'h000E
`define DIV8_LAST 3'h7
`endif
